// ### core/cca_channel_access.sv
// Channel access engine: clear channel checks, random backoff and its APB registers.
//
// What this block and the host do
// [R1] Host enables sensing only for transmission.
// [R2] Host avoids auto acknowledge and retransmission.
// [R3] Check carrier sense before sending any data.
// [R4] Busy retry increments attempt count by one.
// [R5] At limit raise interrupt, drop the packet.
// [R6] Stay asleep or ready during backoff.
// [R7] Persistent mode listens until idle or abort.
// [R8] Wait is random below two-power-attempts units.
// [R9] Contention window doubles with each retry.
// [R10] Seed reload at procedure start when enabled.
// [R11] Enable is protocol bit 11, sampled per packet.
// [R12] Protocol bit 9 selects persistent sensing.
// [R13] Host programs a non-zero seed.
// [R14] Six-bit prescale sets backoff unit length.
// [R15] Sense period code gives 64 to 512 bits.
// [R16] Listen window spans 1 to 15 periods.
// [R17] Three-bit field limits backoff cycles.
// [R18] Backoff timer counts low-power clock ticks.
// [R19] Idle channel sends the packet, ends procedure.
// [R20] Abort command returns the radio to ready.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module cca_channel_access (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tx_request,
    input  wire logic        carrier_sense,
    input  wire logic        bit_tick,
    input  wire logic        rc_tick,
    output logic             tx_go,
    output logic             tx_drop,
    output logic             backoff_limit_irq,
    output logic             listen_on,
    output logic             sleep_on,
    output logic             abort_done
);

    // Software-visible configuration.
    logic [31:0] proto_cfg;
    logic [15:0] access_config;
    logic [15:0] backoff_seed;
    logic        limit_flag;

    // Procedure state.
    cca_pkg::cca_state_type state;
    logic [2:0]  backoff_attempt_count;
    logic [3:0]  period_count;
    logic        window_busy;
    logic [7:0]  units_left;

    // Bus decode.
    logic        access;
    logic        wr;
    logic        mapped;
    logic        abort_command;
    logic        limit_clear;

    // Configuration fields.
    logic        channel_access_enable;
    logic        persistent_sense_enable;
    logic [5:0]  backoff_unit_prescale;
    logic [1:0]  sense_code;
    logic [3:0]  listen_length;
    logic [2:0]  backoff_limit;
    logic        seed_reload;
    logic [9:0]  sense_div;
    logic [3:0]  listen_last;

    // Helpers for the procedure.
    logic        start;
    logic        sense_pulse;
    logic        unit_pulse;
    logic        busy_now;
    logic [2:0]  next_attempt;
    logic [7:0]  window_mask;
    logic [7:0]  next_units;
    logic [15:0] rand_value;

    // One wait state per transfer keeps pready and prdata registered.
    assign access = psel & penable & ~pready;
    assign wr     = access & pwrite;
    assign mapped = (paddr == cca_pkg::ADDR_PROTO)  || (paddr == cca_pkg::ADDR_ACCESS) ||
                    (paddr == cca_pkg::ADDR_SEED)   || (paddr == cca_pkg::ADDR_CMD) ||
                    (paddr == cca_pkg::ADDR_STATUS) || (paddr == cca_pkg::ADDR_RAND);
    assign abort_command = wr & (paddr == cca_pkg::ADDR_CMD) & (pwdata[7:0] == cca_pkg::CMD_ABORT);
    assign limit_clear   = wr & (paddr == cca_pkg::ADDR_STATUS) & pwdata[cca_pkg::STAT_LIMIT_BIT];

    // Field extraction from the configuration words.
    assign channel_access_enable   = proto_cfg[cca_pkg::PROTO_ACCESS_EN_BIT];
    assign persistent_sense_enable = proto_cfg[cca_pkg::PROTO_PERSIST_BIT];
    assign backoff_unit_prescale   = access_config[cca_pkg::ACC_PRESCALE_LSB +: 6];
    assign sense_code              = access_config[cca_pkg::ACC_PERIOD_LSB +: 2];
    assign listen_length           = access_config[cca_pkg::ACC_LISTEN_LSB +: 4];
    assign backoff_limit           = access_config[cca_pkg::ACC_LIMIT_LSB +: 3];
    assign seed_reload             = access_config[cca_pkg::ACC_SEED_LOAD_BIT];

    // Sense interval in bit ticks: 64, 128, 256 or 512.
    assign sense_div = cca_pkg::SENSE_BASE_BITS << sense_code;  // see [R15]

    // A listen length of zero is treated as one period, the shortest legal window.
    assign listen_last = (listen_length == 4'h0) ? 4'h0 : listen_length - 4'h1;  // see [R16]

    // The enable is looked at only when a packet asks to go out.
    assign start = tx_request & state[0] & channel_access_enable & ~abort_command;  // see [R11]

    // Carrier sense sampled once per sense interval, any busy sample spoils the window.
    assign busy_now = window_busy | carrier_sense;  // see [R3]

    // Window for the retry about to start is two to the new attempt count.
    assign next_attempt = backoff_attempt_count + 3'h1;  // see [R4]
    assign window_mask  = 8'hFF >> (4'h8 - {1'b0, next_attempt});  // see [R9]
    assign next_units   = rand_value[7:0] & window_mask;  // see [R8]

    // Sense interval timer runs on bit ticks only while listening.
    cca_tick_div #(
        .W(10)
    ) u_sense_div (
        .clk  (pclk),
        .rst_n(presetn),
        .clear(~state[1]),
        .tick (bit_tick),
        .div  (sense_div),
        .pulse(sense_pulse)
    );

    // Backoff unit timer counts the slow clock, so the radio can sleep meanwhile.
    cca_tick_div #(
        .W(6)
    ) u_unit_div (
        .clk  (pclk),
        .rst_n(presetn),
        .clear(~state[2]),
        .tick (rc_tick),  // see [R18]
        .div  (backoff_unit_prescale),  // see [R14]
        .pulse(unit_pulse)
    );

    // Random source, reseeded at each procedure start when reload is on.
    cca_prng u_prng (
        .clk  (pclk),
        .rst_n(presetn),
        .load (start & seed_reload),  // see [R10]
        .seed (backoff_seed),
        .value(rand_value)
    );

    // Configuration register writes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            proto_cfg     <= cca_pkg::PROTO_RESET;
            access_config <= cca_pkg::ACCESS_RESET;
            backoff_seed  <= cca_pkg::SEED_RESET;
        end else if (wr) begin
            case (paddr)
                cca_pkg::ADDR_PROTO: begin
                    proto_cfg <= pwdata;  // see [R12]
                end
                cca_pkg::ADDR_ACCESS: begin
                    access_config <= pwdata[15:0];  // see [R17]
                end
                cca_pkg::ADDR_SEED: begin
                    backoff_seed <= pwdata[15:0];
                end
                default: begin
                end
            endcase
        end
    end

    // APB answer: one wait state, registered data, error on unmapped addresses.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= access;
            pslverr <= access & ~mapped;
            prdata  <= 32'h0000_0000;
            if (access & ~pwrite) begin
                case (paddr)
                    cca_pkg::ADDR_PROTO:  prdata <= proto_cfg;
                    cca_pkg::ADDR_ACCESS: prdata <= {16'h0000, access_config};
                    cca_pkg::ADDR_SEED:   prdata <= {16'h0000, backoff_seed};
                    cca_pkg::ADDR_STATUS: prdata <= {23'h000000, limit_flag, 1'b0, state, 1'b0,
                                                     backoff_attempt_count};
                    cca_pkg::ADDR_RAND:   prdata <= {16'h0000, rand_value};
                    default:              prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Sticky limit flag; a new limit event in the clearing cycle wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limit_flag <= 1'b0;
        end else if (backoff_limit_irq) begin
            limit_flag <= 1'b1;
        end else if (limit_clear) begin
            limit_flag <= 1'b0;
        end
    end

    // Procedure sequencer: listen, decide, back off, listen again.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state                 <= cca_pkg::ST_IDLE;
            backoff_attempt_count <= 3'h0;
            period_count          <= 4'h0;
            window_busy           <= 1'b0;
            units_left            <= 8'h00;
            tx_go                 <= 1'b0;
            tx_drop               <= 1'b0;
            backoff_limit_irq     <= 1'b0;
            abort_done            <= 1'b0;
        end else begin
            tx_go             <= 1'b0;
            tx_drop           <= 1'b0;
            backoff_limit_irq <= 1'b0;
            abort_done        <= 1'b0;
            if (abort_command) begin
                // Abort wins over everything, including persistent listening.
                state      <= cca_pkg::ST_IDLE;  // see [R20] [R7]
                abort_done <= 1'b1;
            end else begin
                case (state)
                    cca_pkg::ST_IDLE: begin
                        if (tx_request & ~channel_access_enable) begin
                            tx_go <= 1'b1;  // see [R11]
                        end else if (start) begin
                            state                 <= cca_pkg::ST_LISTEN;  // see [R3]
                            backoff_attempt_count <= 3'h0;
                            period_count          <= 4'h0;
                            window_busy           <= 1'b0;
                        end
                    end
                    cca_pkg::ST_LISTEN: begin
                        if (sense_pulse) begin
                            if (period_count < listen_last) begin
                                period_count <= period_count + 4'h1;  // see [R16]
                                window_busy  <= busy_now;
                            end else begin
                                period_count <= 4'h0;
                                window_busy  <= 1'b0;
                                if (!busy_now) begin
                                    tx_go <= 1'b1;  // see [R19]
                                    state <= cca_pkg::ST_IDLE;
                                end else if (persistent_sense_enable) begin
                                    // Keep listening with no backoff until idle.
                                    state <= cca_pkg::ST_LISTEN;  // see [R7] [R12]
                                end else if (backoff_attempt_count == backoff_limit) begin
                                    backoff_limit_irq <= 1'b1;  // see [R5] [R17]
                                    tx_drop           <= 1'b1;
                                    state             <= cca_pkg::ST_IDLE;
                                end else begin
                                    backoff_attempt_count <= next_attempt;  // see [R4]
                                    units_left            <= next_units;  // see [R8]
                                    // A zero draw means no wait: listen again at once.
                                    if (next_units != 8'h00) begin
                                        state <= cca_pkg::ST_BACKOFF;  // see [R6]
                                    end
                                end
                            end
                        end
                    end
                    cca_pkg::ST_BACKOFF: begin
                        if (unit_pulse) begin
                            units_left <= units_left - 8'h01;  // see [R18]
                            if (units_left == 8'h01) begin
                                state <= cca_pkg::ST_LISTEN;
                            end
                        end
                    end
                    default: begin
                        state <= cca_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Radio control levels follow the state one clock later; the receiver is off in backoff.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            listen_on <= 1'b0;
            sleep_on  <= 1'b0;
        end else begin
            listen_on <= state[1];
            sleep_on  <= state[2];  // see [R6]
        end
    end

endmodule

`default_nettype wire

// ### core/cca_pkg.sv
// Shared constants and types for the channel access engine.
`default_nettype none

package cca_pkg;

    // Register byte offsets on the APB slave.
    localparam logic [7:0] ADDR_PROTO  = 8'h00;
    localparam logic [7:0] ADDR_ACCESS = 8'h04;
    localparam logic [7:0] ADDR_SEED   = 8'h08;
    localparam logic [7:0] ADDR_CMD    = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_RAND   = 8'h14;

    // Second protocol configuration register bit positions.
    localparam int PROTO_ACCESS_EN_BIT = 11;
    localparam int PROTO_PERSIST_BIT   = 9;

    // Access configuration register field positions.
    localparam int ACC_PRESCALE_LSB  = 0;
    localparam int ACC_PERIOD_LSB    = 6;
    localparam int ACC_LISTEN_LSB    = 8;
    localparam int ACC_LIMIT_LSB     = 12;
    localparam int ACC_SEED_LOAD_BIT = 15;

    // Status register field positions.
    localparam int STAT_ATTEMPT_LSB = 0;
    localparam int STAT_STATE_LSB   = 4;
    localparam int STAT_LIMIT_BIT   = 8;

    // Values after reset.
    localparam logic [31:0] PROTO_RESET  = 32'h0000_0000;
    localparam logic [15:0] ACCESS_RESET = 16'h3101;
    localparam logic [15:0] SEED_RESET   = 16'h0001;

    // Command code that stops the procedure and returns the radio to ready.
    localparam logic [7:0] CMD_ABORT = 8'h67;

    // Shortest carrier-sense interval in bit periods; each code step doubles it.
    localparam logic [9:0] SENSE_BASE_BITS = 10'h040;

    // Procedure states, one-hot.
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_LISTEN  = 3'b010,
        ST_BACKOFF = 3'b100
    } cca_state_type;

endpackage

`default_nettype wire

// ### core/cca_prng.sv
// Sixteen-bit pseudo-random generator for the backoff draw.
`timescale 1ns/100ps
`default_nettype none

module cca_prng (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        load,
    input  wire logic [15:0] seed,
    output logic [15:0]      value
);

    logic feedback;

    // Maximal-length taps; an all-zero state stays zero, so software must avoid it.
    assign feedback = value[15] ^ value[13] ^ value[12] ^ value[10];

    // Steps every clock so the draw also depends on request timing.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value <= cca_pkg::SEED_RESET;
        end else if (load) begin
            value <= seed;
        end else begin
            value <= {value[14:0], feedback};
        end
    end

endmodule

`default_nettype wire

// ### core/cca_tick_div.sv
// Divider that emits one pulse for every div input ticks.
`timescale 1ns/100ps
`default_nettype none

module cca_tick_div #(
    parameter int W = 6
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         clear,
    input  wire logic         tick,
    input  wire logic [W-1:0] div,
    output logic              pulse
);

    logic [W-1:0] count;
    logic [W-1:0] last;

    // A divide value of zero would never end, so it behaves as one.
    assign last = (div == '0) ? '0 : div - W'(1);

    // Count ticks and pulse on the last one of each group.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            pulse <= 1'b0;
        end else if (clear) begin
            count <= '0;
            pulse <= 1'b0;
        end else begin
            pulse <= 1'b0;
            if (tick) begin
                if (count >= last) begin
                    count <= '0;
                    pulse <= 1'b1;
                end else begin
                    count <= count + W'(1);
                end
            end
        end
    end

endmodule

`default_nettype wire

// ### verification/cca_channel_access_assertions.sv
// Concurrent checks on the ports of the channel access engine.
`timescale 1ns/100ps
`default_nettype none

module cca_channel_access_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        tx_request,
    input wire logic        carrier_sense,
    input wire logic        bit_tick,
    input wire logic        rc_tick,
    input wire logic        tx_go,
    input wire logic        tx_drop,
    input wire logic        backoff_limit_irq,
    input wire logic        listen_on,
    input wire logic        sleep_on,
    input wire logic        abort_done
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // An access phase still waiting for its answer; the command write is the abort trigger.
    logic taken;
    logic abort_wr;
    assign taken    = psel && penable && !pready;
    assign abort_wr = taken && pwrite && paddr == cca_pkg::ADDR_CMD && pwdata[7:0] == cca_pkg::CMD_ABORT;

    a_ready_follows: assert property (taken |=> pready) else $error("pready missing after access");
    a_ready_single: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_rdata_quiet: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero outside answer");
    a_limit_drops: assert property (backoff_limit_irq |-> tx_drop && !tx_go)
        else $error("limit without drop");
    a_drop_has_irq: assert property (tx_drop |-> backoff_limit_irq)
        else $error("drop without limit irq");
    a_go_awake: assert property (tx_go |-> !sleep_on)
        else $error("send during backoff");
    a_sleep_alone: assert property (sleep_on |-> !listen_on && !tx_go)
        else $error("sensing while asleep");
    a_abort_taken: assert property (abort_wr |-> ##[1:2] abort_done)
        else $error("abort not acknowledged");
    a_abort_idle: assert property (abort_done |-> ##[1:2] (!listen_on && !sleep_on))
        else $error("busy after abort");
    a_abort_no_go: assert property (abort_done |=> !tx_go)
        else $error("send after abort");

    c_go: cover property (tx_go);
    c_limit: cover property (backoff_limit_irq);
    c_abort: cover property (abort_done);
    c_backoff: cover property (sleep_on ##1 !sleep_on);
endmodule

`default_nettype wire

// ### verification/cca_channel_access_bench.sv
// Self-checking bench for the channel access engine.
`timescale 1ns/100ps
`default_nettype none

module cca_channel_access_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_request, busy;
    logic        carrier_sense, bit_tick, rc_tick, tx_go, tx_drop, backoff_limit_irq;
    logic        listen_on, sleep_on, abort_done, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] s16;
    logic [3:0]  ln;
    logic [1:0]  cd;
    int          n_errors, compares, cyc, n_go, n_irq, n_abort, nsl, slen, lim, pre, c, c2, g, i0;
    int          seed;

    cca_channel_access uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .tx_request, .carrier_sense, .bit_tick, .rc_tick, .tx_go, .tx_drop, .backoff_limit_irq,
        .listen_on, .sleep_on, .abort_done);
    cca_radio_model radio (.pclk, .presetn, .busy, .bit_tick, .rc_tick, .carrier_sense);

    initial pclk = 1'b0;
    always #2.5 pclk = ~pclk;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task give_verdict;
        $display("Mismatches %0d, comparisons %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // One APB transfer; the request is held until pready is seen at a rising edge, and only the hang guard ends the wait.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Start aligned to the tick phases so identical set-ups replay identically; c counts to the outcome.
    task send;
        while (cyc % 6 != 0) @(posedge pclk);
        g = n_go + n_irq;
        tx_request <= 1'b1;
        @(posedge pclk);
        tx_request <= 1'b0;
        c = 0;
        while (n_go + n_irq == g && c < 20000) begin
            @(posedge pclk);
            c++;
        end
    endtask

    function automatic int win(int code, int len);
        return (64 << code) * len * 2;
    endfunction

    // Event counters, backoff length bound and the hang guard.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (tx_go === 1'b1) n_go <= n_go + 1;
        if (backoff_limit_irq === 1'b1) n_irq <= n_irq + 1;
        if (abort_done === 1'b1) n_abort <= n_abort + 1;
        if (sleep_on === 1'b1) slen <= slen + 1;
        else if (slen != 0) begin
            chk(slen <= ((1 << lim) - 1) * pre * 3 + 4, 1);
            slen <= 0;
            nsl <= nsl + 1;
        end
        if (cyc == 90000) begin
            n_errors++;
            give_verdict;
        end
    end

    initial begin
        seed = 32'h902E;
        {presetn, psel, penable, pwrite, tx_request, busy} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        {n_errors, compares, cyc, n_go, n_irq, n_abort, nsl, slen, lim, pre} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, an unmapped address and the write-only command word.
        apb(1'b0, cca_pkg::ADDR_PROTO, 32'h0);
        chk(r, cca_pkg::PROTO_RESET);
        apb(1'b0, cca_pkg::ADDR_ACCESS, 32'h0);
        chk(r, {16'h0, cca_pkg::ACCESS_RESET});
        apb(1'b0, cca_pkg::ADDR_SEED, 32'h0);
        chk(r, {16'h0, cca_pkg::SEED_RESET});
        apb(1'b0, cca_pkg::ADDR_STATUS, 32'h0);
        chk(r, 32'h10);
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        apb(1'b0, cca_pkg::ADDR_CMD, 32'h0);
        chk(r, 32'h0);
        // The generator word sits in the low half and never reaches zero from a non-zero seed.
        apb(1'b0, cca_pkg::ADDR_RAND, 32'h0);
        chk(r[31:16], 16'h0);
        chk(r[15:0] != 16'h0, 1);
        // With sensing off a request is sent at once.
        send;
        chk(c < 6, 1);
        // Sensing on for transmit only, no link-layer features; every sense code and a longer listen.
        apb(1'b1, cca_pkg::ADDR_PROTO, 32'h800);
        for (int k = 0; k < 5; k++) begin
            cd = k[1:0];
            ln = (k == 4) ? 4'h3 : 4'h1;
            apb(1'b1, cca_pkg::ADDR_ACCESS, {20'h0, ln, cd, 6'h01});
            send;
            chk(c + 2 >= win(cd, ln) && c <= win(cd, ln) + 8, 1);
        end
        // Busy channel to the attempt limit: zero, the maximum and random limits, replayed with the same seed.
        for (int k = 0; k < 4; k++) begin
            lim = (k == 0) ? 0 : (k == 1) ? 7 : $random(seed) & 7;
            pre = ($random(seed) & 3) + 1;
            s16 = 16'($random(seed)) | 16'h0001;
            apb(1'b1, cca_pkg::ADDR_SEED, {16'h0, s16});
            apb(1'b1, cca_pkg::ADDR_ACCESS, {16'h0, 1'b1, lim[2:0], 4'h1, 2'h0, pre[5:0]});
            busy <= 1'b1;
            for (int j = 0; j < 2; j++) begin
                nsl = 0;
                i0 = n_irq;
                c2 = c;
                send;
                chk(n_irq, i0 + 1);
                chk(nsl <= lim, 1);
                if (j == 1) chk(c, c2);
            end
            apb(1'b0, cca_pkg::ADDR_STATUS, 32'h0);
            chk(r[8:4], 5'h11);
            apb(1'b1, cca_pkg::ADDR_STATUS, 32'h100);
            apb(1'b0, cca_pkg::ADDR_STATUS, 32'h0);
            chk(r[8], 1'b0);
        end
        chk(n_go, 6);
        // Persistent sensing keeps listening without backoff until aborted.
        apb(1'b1, cca_pkg::ADDR_PROTO, 32'hA00);
        nsl = 0;
        i0 = n_irq;
        tx_request <= 1'b1;
        @(posedge pclk);
        tx_request <= 1'b0;
        repeat (1000) @(posedge pclk);
        chk({listen_on, nsl[7:0], n_irq[7:0]}, {1'b1, 8'h0, i0[7:0]});
        g = n_abort;
        apb(1'b1, cca_pkg::ADDR_CMD, {24'h0, cca_pkg::CMD_ABORT});
        repeat (3) @(posedge pclk);
        chk({n_abort[7:0], listen_on}, {g[7:0] + 8'h1, 1'b0});
        // Persistent sensing ends when the channel clears.
        fork
            send;
            begin
                repeat (300) @(posedge pclk);
                busy <= 1'b0;
            end
        join
        chk(c > 290 && c < 300 + 2 * win(0, 1) + 10, 1);
        give_verdict;
    end
endmodule

bind cca_channel_access cca_channel_access_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .tx_request, .carrier_sense, .bit_tick, .rc_tick, .tx_go, .tx_drop,
    .backoff_limit_irq, .listen_on, .sleep_on, .abort_done);

`default_nettype wire

// ### verification/cca_radio_model.sv
// Behavioural radio front end: bit and low-power clock ticks and the carrier sense flag.
`timescale 1ns/100ps
`default_nettype none

module cca_radio_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic busy,
    output logic      bit_tick,
    output logic      rc_tick,
    output logic      carrier_sense
);
    logic       bit_ph;
    logic [1:0] rc_ph;

    // Bit ticks every second cycle, RC ticks every third, so the two time bases line up only once every sixth cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_ph <= 1'b0;
            rc_ph  <= 2'h0;
        end else begin
            bit_ph <= !bit_ph;
            rc_ph  <= (rc_ph == 2'h2) ? 2'h0 : rc_ph + 2'h1;
        end
    end
    assign bit_tick = bit_ph;
    assign rc_tick  = (rc_ph == 2'h2);

    // The receiver reports the channel one cycle late, like a real RSSI comparator output.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carrier_sense <= 1'b0;
        end else begin
            carrier_sense <= busy;
        end
    end
endmodule

`default_nettype wire
